// file: hdl/pie_exec.sv
// instruction executor: accumulator stack, timer and counter loads,
// arithmetic, block call and finish requests, stop, and bit logic scans.
// assumes one instruction per cycle from the program sequencer, and that
// the timer and counter machinery writes the locations in binary.
// Summary of operation
// - direct timer load puts only the binary count in accumulator 1
// - coded timer load puts BCD time value plus time base in acc 1
// - coded loads write zero in place of the status bits
// - locations hold binary; read either directly or BCD converted
// - arithmetic uses accumulators 1 and 2, result to accumulator 1
// - after arithmetic acc2 gets acc3, acc3 gets acc4, acc4 stays
// - signed 16-bit fixed add, subtract, multiply, plus fixed divide
// - floating point add, subtract, multiply and divide
// - block calls unconditional or on set result bit, numbers to 255
// - extended function blocks 0 to 255 called either way
// - data blocks 3 to 255, extended data blocks 1 to 255
// - plain, conditional and unconditional block finish
// - idle forms and display marker leave machine state unchanged
// - halt instruction moves the processor into stop state
// - AND scans drive the output low when any input is low
// - OR scans drive the output high when any input is high
// - OR scans drive the output low only when all inputs low
module pie_exec #(
  parameter int NUM_LOC = 128,
  parameter int NUM_IN  = 128,
  parameter int NUM_OUT = 128
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // instruction stream
  input  wire logic                 instValid,
  input  wire pie_pkg::pie_op_t     instOp,
  input  wire pie_pkg::pie_blk_t    instKind,
  input  wire logic [7:0]           instParam,
  input  wire logic [31:0]          instData,
  output logic                      instReady,
  // timer and counter location write port
  input  wire logic                 locWrEn,
  input  wire logic                 locIsCnt,
  input  wire logic [6:0]           locIdx,
  input  wire logic [15:0]          locData,
  // process inputs and outputs
  input  wire logic [NUM_IN-1:0]    pinIn,
  output logic      [NUM_OUT-1:0]   outBits,
  // block control requests
  output logic                      callValid,
  output pie_pkg::pie_blk_t         callKind,
  output logic      [7:0]           callNum,
  output logic                      finishValid,
  output logic      [7:0]           dataBlk,
  output logic                      dataBlkExt,
  output logic                      instFault,
  // status
  output logic      [31:0]          acc1,
  output logic                      logicResultBit,
  output logic                      stopped
);
  // ---------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------
  logic [NUM_IN-1:0] syncA;
  logic [NUM_IN-1:0] syncB;
  logic [NUM_IN-1:0] syncC;
  logic [NUM_IN-1:0] inImage;

  for (genvar g = 0; g < NUM_IN; g++) begin : gSync
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        syncA[g]   <= 1'b0;
        syncB[g]   <= 1'b0;
        syncC[g]   <= 1'b0;
        inImage[g] <= 1'b0;
      end else begin
        syncA[g] <= pinIn[g];
        syncB[g] <= syncA[g];
        syncC[g] <= syncB[g];
        if (syncB[g] == syncC[g]) inImage[g] <= syncC[g];
      end
    end
  end

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  pie_pkg::pie_state_t state_reg;
  logic        exec;
  logic [31:0] acc2_reg;
  logic [31:0] acc3_reg;
  logic [31:0] acc4_reg;
  logic [31:0] acc1_reg;
  logic        lrb_reg;
  logic        first_reg;
  logic        scanBit;
  logic        isArith;
  logic        isLoad;
  logic [31:0] loadVal;
  logic [31:0] aluRes;
  logic        aluDivZero;
  logic [1:0]  aluSel;

  assign instReady = (state_reg == pie_pkg::ST_RUN);
  assign exec      = instValid && instReady;
  assign scanBit   = inImage[instParam[6:0]];
  assign isArith   = (instOp >= pie_pkg::OP_FIX_ADD) &&
                     (instOp <= pie_pkg::OP_FLT_DIV);
  assign isLoad    = (instOp >= pie_pkg::OP_LOAD_CONST) &&
                     (instOp <= pie_pkg::OP_CODED_CNT);
  assign aluSel    = 2'((instOp - pie_pkg::OP_FIX_ADD) & 5'h03);

  pie_alu uAlu (
    .opA     (acc2_reg),
    .opB     (acc1_reg),
    .aluOp   (pie_pkg::pie_alu_t'(aluSel)),
    .isFloat (instOp >= pie_pkg::OP_FLT_ADD),
    .result  (aluRes),
    .divZero (aluDivZero)
  );

  // ---------------------------------------------------------------------
  // timer and counter locations
  // ---------------------------------------------------------------------
  // separate arrays so a timer and counter of the same number never alias
  logic [15:0] tmrMem [NUM_LOC];
  logic [15:0] cntMem [NUM_LOC];
  logic [15:0] locWord;
  logic [9:0]  locVal;
  logic [11:0] locBcd;

  always_ff @(posedge clk) begin
    if (locWrEn && !locIsCnt) tmrMem[locIdx] <= locData;
    if (locWrEn && locIsCnt) cntMem[locIdx] <= locData;
  end

  function automatic logic [11:0] toBcd(input logic [9:0] bin);
    logic [21:0] sh;
    sh = {12'h000, bin};
    for (int i = 0; i < 10; i++) begin
      for (int d = 0; d < 3; d++) begin
        if (sh[10 + 4*d +: 4] > 4'h4) sh[10 + 4*d +: 4] += 4'h3;
      end
      sh = sh << 1;
    end
    toBcd = sh[21:10];
  endfunction : toBcd

  assign locWord = (instOp == pie_pkg::OP_LOAD_TMR ||
                    instOp == pie_pkg::OP_CODED_TMR) ?
                   tmrMem[instParam[6:0]] : cntMem[instParam[6:0]];
  assign locVal  = locWord[pie_pkg::VAL_LSB +: pie_pkg::VAL_W];
  // a value above 999 cannot occur when the count is kept legal
  assign locBcd  = toBcd(locVal);

  always_comb begin
    loadVal = instData;
    unique case (instOp)
      pie_pkg::OP_LOAD_TMR,
      pie_pkg::OP_LOAD_CNT:  loadVal = {22'h000000, locVal};
      pie_pkg::OP_CODED_TMR: loadVal = {18'h00000,
                               locWord[pie_pkg::TB_LSB +: pie_pkg::TB_W],
                               locBcd};
      pie_pkg::OP_CODED_CNT: loadVal = {20'h00000, locBcd};
      default:               loadVal = instData;
    endcase
  end

  // ---------------------------------------------------------------------
  // accumulator stack
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc1_reg <= 32'h0000_0000;
      acc2_reg <= 32'h0000_0000;
      acc3_reg <= 32'h0000_0000;
      acc4_reg <= 32'h0000_0000;
    end else if (exec && isLoad) begin
      acc1_reg <= loadVal;
      acc2_reg <= acc1_reg;
    end else if (exec && isArith) begin
      acc1_reg <= aluRes;
      acc2_reg <= acc3_reg;
      acc3_reg <= acc4_reg;
    end
  end
  assign acc1 = acc1_reg;

  // ---------------------------------------------------------------------
  // logic scans and outputs
  // ---------------------------------------------------------------------
  // the first scan after an assignment starts a new chain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lrb_reg   <= 1'b0;
      first_reg <= 1'b1;
    end else if (exec && instOp == pie_pkg::OP_AND_SCAN) begin
      lrb_reg   <= (first_reg || lrb_reg) && scanBit;
      first_reg <= 1'b0;
    end else if (exec && instOp == pie_pkg::OP_OR_SCAN) begin
      lrb_reg   <= (!first_reg && lrb_reg) || scanBit;
      first_reg <= 1'b0;
    end else if (exec && instOp == pie_pkg::OP_ASSIGN) begin
      first_reg <= 1'b1;
    end
  end
  assign logicResultBit = lrb_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      outBits <= '0;
    end else if (exec && instOp == pie_pkg::OP_ASSIGN &&
                 int'(instParam) < NUM_OUT) begin
      outBits[instParam[6:0]] <= lrb_reg;
    end
  end

  // ---------------------------------------------------------------------
  // block calls, data blocks and finish
  // ---------------------------------------------------------------------
  logic callGo;
  logic callBad;
  logic dbBad;

  assign callGo  = exec && (instOp == pie_pkg::OP_CALL_U ||
                   (instOp == pie_pkg::OP_CALL_C && lrb_reg));
  assign callBad = (instKind == pie_pkg::BLK_ORG) && (instParam < pie_pkg::OB_MIN);
  assign dbBad   = (instOp == pie_pkg::OP_SEL_DB) ?
                   (instParam < pie_pkg::DB_MIN) : (instParam < pie_pkg::DX_MIN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      callValid   <= 1'b0;
      callKind    <= pie_pkg::BLK_ORG;
      callNum     <= 8'h00;
      finishValid <= 1'b0;
      instFault   <= 1'b0;
    end else begin
      callValid   <= callGo && !callBad;
      finishValid <= exec && (instOp == pie_pkg::OP_FINISH ||
                     instOp == pie_pkg::OP_FINISH_U ||
                     (instOp == pie_pkg::OP_FINISH_C && lrb_reg));
      instFault   <= (callGo && callBad) ||
                     (exec && (instOp == pie_pkg::OP_SEL_DB ||
                      instOp == pie_pkg::OP_SEL_DX) && dbBad) ||
                     (exec && isArith && aluDivZero) ||
                     (exec && instOp == pie_pkg::OP_IDLE &&
                      instParam > pie_pkg::IDLE_MAX);
      if (callGo && !callBad) begin
        callKind <= instKind;
        callNum  <= instParam;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataBlk    <= 8'h00;
      dataBlkExt <= 1'b0;
    end else if (exec && (instOp == pie_pkg::OP_SEL_DB ||
                 instOp == pie_pkg::OP_SEL_DX) && !dbBad) begin
      dataBlk    <= instParam;
      dataBlkExt <= (instOp == pie_pkg::OP_SEL_DX);
    end
  end

  // ---------------------------------------------------------------------
  // run and stop
  // ---------------------------------------------------------------------
  // only reset leaves the stop state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_reg <= pie_pkg::ST_RUN;
    else if (exec && instOp == pie_pkg::OP_HALT)
      state_reg <= pie_pkg::ST_STOP;
  end
  assign stopped = (state_reg == pie_pkg::ST_STOP);

  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_direct_load: assert property (
    exec && instOp == pie_pkg::OP_LOAD_TMR |=>
    acc1_reg == {22'h000000, $past(locVal)})
    else $error("direct timer load value wrong");
  a_coded_zero: assert property (
    exec && instOp == pie_pkg::OP_CODED_CNT |=> acc1_reg[31:12] == 20'h00000)
    else $error("coded counter load status bits not zero");
  a_coded_tbase: assert property (
    exec && instOp == pie_pkg::OP_CODED_TMR |=> acc1_reg[31:14] == 18'h00000
    && acc1_reg[13:12] == $past(locWord[13:12]))
    else $error("coded timer load time base wrong");
  a_stack_shift: assert property (exec && isArith |=>
    acc2_reg == $past(acc3_reg) && acc3_reg == $past(acc4_reg) &&
    $stable(acc4_reg))
    else $error("stack not shifted after arithmetic");
  a_fix_add: assert property (
    exec && instOp == pie_pkg::OP_FIX_ADD |=>
    acc1_reg[15:0] == 16'($past(acc2_reg[15:0]) + $past(acc1_reg[15:0])))
    else $error("fixed add result wrong");
  a_cond_call: assert property (
    exec && instOp == pie_pkg::OP_CALL_C && !lrb_reg |=> !callValid)
    else $error("conditional call taken with result bit clear");
  a_cond_finish: assert property (
    exec && instOp == pie_pkg::OP_FINISH_C |=> finishValid == $past(lrb_reg))
    else $error("conditional finish mismatch");
  a_idle_stable: assert property (
    exec && (instOp == pie_pkg::OP_IDLE || instOp == pie_pkg::OP_DISPLAY) |=>
    $stable(acc1_reg) && $stable(lrb_reg) && $stable(outBits))
    else $error("idle instruction changed state");
  a_halt_stop: assert property (
    exec && instOp == pie_pkg::OP_HALT |=> (stopped && !instReady) [*3])
    else $error("halt did not stop");
  a_and_low: assert property (
    exec && instOp == pie_pkg::OP_AND_SCAN && !scanBit |=> !lrb_reg)
    else $error("and scan with low input not low");
  a_or_high: assert property (
    exec && instOp == pie_pkg::OP_OR_SCAN && scanBit |=> lrb_reg)
    else $error("or scan with high input not high");
  a_db_range: assert property (
    exec && instOp == pie_pkg::OP_SEL_DB && instParam < pie_pkg::DB_MIN |=>
    $stable(dataBlk) && instFault)
    else $error("data block below range accepted");

  c_call: cover property (callValid && callKind == pie_pkg::BLK_XFUNC);
  c_flt_div: cover property (exec && instOp == pie_pkg::OP_FLT_DIV);
  c_coded: cover property (exec && instOp == pie_pkg::OP_CODED_TMR);
  c_stop: cover property (stopped);
endmodule : pie_exec

// file: hdl/pie_alu.sv
// shared constants and types for the instruction executor, and the
// fixed and floating point arithmetic unit that it instantiates.
// assumes operands come straight from the accumulator stack; the unit is
// purely combinational, so the result is ready in the same cycle.
package pie_pkg;
  // ---------------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_IDLE       = 5'h00,
    OP_DISPLAY    = 5'h01,
    OP_LOAD_CONST = 5'h02,
    OP_LOAD_TMR   = 5'h03,
    OP_LOAD_CNT   = 5'h04,
    OP_CODED_TMR  = 5'h05,
    OP_CODED_CNT  = 5'h06,
    OP_FIX_ADD    = 5'h07,
    OP_FIX_SUB    = 5'h08,
    OP_FIX_MUL    = 5'h09,
    OP_FIX_DIV    = 5'h0a,
    OP_FLT_ADD    = 5'h0b,
    OP_FLT_SUB    = 5'h0c,
    OP_FLT_MUL    = 5'h0d,
    OP_FLT_DIV    = 5'h0e,
    OP_CALL_U     = 5'h0f,
    OP_CALL_C     = 5'h10,
    OP_SEL_DB     = 5'h11,
    OP_SEL_DX     = 5'h12,
    OP_FINISH     = 5'h13,
    OP_FINISH_C   = 5'h14,
    OP_FINISH_U   = 5'h15,
    OP_HALT       = 5'h16,
    OP_AND_SCAN   = 5'h17,
    OP_OR_SCAN    = 5'h18,
    OP_ASSIGN     = 5'h19
  } pie_op_t;

  typedef enum logic [2:0] {
    BLK_ORG  = 3'h0,
    BLK_PROG = 3'h1,
    BLK_FUNC = 3'h2,
    BLK_SEQ  = 3'h3,
    BLK_XFUNC = 3'h4
  } pie_blk_t;

  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_SUB = 2'h1,
    ALU_MUL = 2'h2,
    ALU_DIV = 2'h3
  } pie_alu_t;

  typedef enum logic [0:0] {
    ST_RUN  = 1'h0,
    ST_STOP = 1'h1
  } pie_state_t;

  // ---------------------------------------------------------------------
  // timer and counter word layout
  // ---------------------------------------------------------------------
  localparam int VAL_LSB  = 0;
  localparam int VAL_W    = 10;
  localparam int TB_LSB   = 12;
  localparam int TB_W     = 2;
  localparam int BCD_W    = 12;
  localparam int LOC_W    = 16;
  localparam int ACC_W    = 32;
  localparam int FIX_W    = 16;
  localparam logic [7:0] DB_MIN = 8'h03;
  localparam logic [7:0] DX_MIN = 8'h01;
  localparam logic [7:0] OB_MIN = 8'h01;
  localparam logic [7:0] IDLE_MAX = 8'h01;
  // ---------------------------------------------------------------------
  // floating point format
  // ---------------------------------------------------------------------
  localparam int FP_MW = 23;
  localparam int FP_EW = 8;
  localparam logic [9:0] FP_BIAS = 10'h07f;
  localparam logic [9:0] FP_EMAX = 10'h0ff;
endpackage : pie_pkg

module pie_alu (
  // operands: a is the second accumulator, b the first
  input  wire logic [31:0]     opA,
  input  wire logic [31:0]     opB,
  input  wire pie_pkg::pie_alu_t aluOp,
  input  wire logic            isFloat,
  // result
  output logic      [31:0]     result,
  output logic                 divZero
);
  // ---------------------------------------------------------------------
  // floating point helpers
  // ---------------------------------------------------------------------
  // truncating, no denormals; zero exponent means zero, overflow saturates
  function automatic logic [31:0] fpPack(input logic s, input logic [9:0] e,
                                         input logic [22:0] m);
    if (e[9] || e == 10'h000) fpPack = 32'h0000_0000;
    else if (e >= pie_pkg::FP_EMAX) fpPack = {s, 8'hff, 23'h000000};
    else fpPack = {s, e[7:0], m};
  endfunction : fpPack

  function automatic logic [31:0] fpAdd(input logic [31:0] a,
                                        input logic [31:0] b);
    logic [31:0] x;
    logic [31:0] y;
    logic [7:0]  d;
    logic [24:0] mx;
    logic [24:0] my;
    logic [24:0] s;
    logic [9:0]  e;
    x = (a[30:0] >= b[30:0]) ? a : b;
    y = (a[30:0] >= b[30:0]) ? b : a;
    d = x[30:23] - y[30:23];
    mx = (x[30:23] == 8'h00) ? 25'h0 : {2'b01, x[22:0]};
    my = (y[30:23] == 8'h00) ? 25'h0 : {2'b01, y[22:0]};
    my = (d > 8'h18) ? 25'h0 : my >> d;
    s = (x[31] == y[31]) ? mx + my : mx - my;
    e = {2'b00, x[30:23]};
    if (s[24]) begin
      s = s >> 1;
      e = e + 10'h001;
    end
    for (int i = 0; i < 24; i++) begin
      if (!s[23] && s != 25'h0) begin
        s = s << 1;
        e = e - 10'h001;
      end
    end
    fpAdd = (s == 25'h0) ? 32'h0000_0000 : fpPack(x[31], e, s[22:0]);
  endfunction : fpAdd

  function automatic logic [31:0] fpMul(input logic [31:0] a,
                                        input logic [31:0] b);
    logic [47:0] p;
    logic [9:0]  e;
    p = {24'h0, 1'b1, a[22:0]} * {24'h0, 1'b1, b[22:0]};
    e = {2'b00, a[30:23]} + {2'b00, b[30:23]} - pie_pkg::FP_BIAS;
    if (p[47]) e = e + 10'h001;
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00) fpMul = 32'h0000_0000;
    else fpMul = fpPack(a[31] ^ b[31], e, p[47] ? p[46:24] : p[45:23]);
  endfunction : fpMul

  function automatic logic [31:0] fpDiv(input logic [31:0] a,
                                        input logic [31:0] b);
    logic [47:0] q;
    logic [9:0]  e;
    q = {1'b1, a[22:0], 24'h0} / {24'h0, 1'b1, b[22:0]};
    e = {2'b00, a[30:23]} - {2'b00, b[30:23]} + pie_pkg::FP_BIAS;
    if (!q[24]) e = e - 10'h001;
    if (a[30:23] == 8'h00) fpDiv = 32'h0000_0000;
    else fpDiv = fpPack(a[31] ^ b[31], e, q[24] ? q[23:1] : q[22:0]);
  endfunction : fpDiv

  // ---------------------------------------------------------------------
  // operation select
  // ---------------------------------------------------------------------
  logic signed [15:0] fa;
  logic signed [15:0] fb;
  logic signed [31:0] prod;
  logic signed [15:0] quot;

  assign fa   = opA[15:0];
  assign fb   = opB[15:0];
  assign prod = 32'(fa) * 32'(fb);
  // a zero divisor yields zero rather than an undefined quotient
  assign quot = (fb == 16'sh0000) ? 16'sh0000 : fa / fb;

  always_comb begin
    divZero = 1'b0;
    result  = 32'h0000_0000;
    if (isFloat) begin
      unique case (aluOp)
        pie_pkg::ALU_ADD: result = fpAdd(opA, opB);
        pie_pkg::ALU_SUB: result = fpAdd(opA, {~opB[31], opB[30:0]});
        pie_pkg::ALU_MUL: result = fpMul(opA, opB);
        pie_pkg::ALU_DIV: begin
          divZero = (opB[30:23] == 8'h00);
          result  = divZero ? {opA[31] ^ opB[31], 8'hff, 23'h000000}
                            : fpDiv(opA, opB);
        end
      endcase
    end else begin
      unique case (aluOp)
        pie_pkg::ALU_ADD: result = {opA[31:16], 16'(fa + fb)};
        pie_pkg::ALU_SUB: result = {opA[31:16], 16'(fa - fb)};
        pie_pkg::ALU_MUL: result = prod;
        pie_pkg::ALU_DIV: begin
          divZero = (fb == 16'sh0000);
          result  = {16'h0000, quot};
        end
      endcase
    end
  end
endmodule : pie_alu

// file: verification/pie_prog_model.sv
// program memory model: hands instructions and location words to the
// executor; assumes the caller runs in step with the falling clock edge
module pie_prog_model (
  // clock
  input  wire logic         clk,
  // instruction stream
  output logic              instValid,
  output pie_pkg::pie_op_t  instOp,
  output pie_pkg::pie_blk_t instKind,
  output logic [7:0]        instParam,
  output logic [31:0]       instData,
  // location write port
  output logic              locWrEn,
  output logic              locIsCnt,
  output logic [6:0]        locIdx,
  output logic [15:0]       locData
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  initial begin
    {instValid, locWrEn, locIsCnt, locIdx, locData} = '0;
    instOp    = pie_pkg::OP_IDLE;
    instKind  = pie_pkg::BLK_ORG;
    instParam = 8'h00;
    instData  = 32'h0000_0000;
  end
  // idle param and data fields are inverted so a stale value never looks valid
  task automatic issue(input pie_pkg::pie_op_t op,
                       input pie_pkg::pie_blk_t k, input logic [7:0] p,
                       input logic [31:0] d);
    repeat ($urandom_range(1, 2)) @(negedge clk);
    instValid = 1'b1;
    instOp    = op;
    instKind  = k;
    instParam = p;
    instData  = d;
    @(negedge clk);
    instValid = 1'b0;
    instParam = ~p;
    instData  = ~d;
  endtask : issue
  task automatic locWrite(input logic c, input logic [6:0] i,
                          input logic [15:0] d);
    @(negedge clk);
    {locWrEn, locIsCnt, locIdx, locData} = {1'b1, c, i, d};
    @(negedge clk);
    locWrEn = 1'b0;
    locData = ~d;
  endtask : locWrite
endmodule : pie_prog_model

// file: verification/tb_pie_exec.sv
// self-checking bench for the instruction executor
// assumes the program memory model drives the instruction stream
module tb_pie_exec;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // signals and helpers
  // ---------------------------------------------------------------
  logic clk, rstn, instValid, instReady, locWrEn, locIsCnt, callValid;
  logic finishValid, dataBlkExt, instFault, logicResultBit, stopped;
  pie_pkg::pie_op_t  instOp;
  pie_pkg::pie_blk_t instKind, callKind, kd, lk;
  logic [7:0]   instParam, callNum, dataBlk, ln, n;
  logic [31:0]  instData, acc1;
  logic [6:0]   locIdx;
  logic [15:0]  locData, a, b;
  logic [127:0] pinIn, outBits;
  logic [31:0]  m [1:4];
  logic [31:0]  fr [4] = '{32'h40600000, 32'hbf000000, 32'h40400000,
                           32'h3f400000};
  int err_total, check_count;
  pie_exec i_pie_exec (.clk(clk), .rstn(rstn), .instValid(instValid),
    .instOp(instOp), .instKind(instKind), .instParam(instParam),
    .instData(instData), .instReady(instReady), .locWrEn(locWrEn),
    .locIsCnt(locIsCnt), .locIdx(locIdx), .locData(locData),
    .pinIn(pinIn), .outBits(outBits), .callValid(callValid),
    .callKind(callKind), .callNum(callNum), .finishValid(finishValid),
    .dataBlk(dataBlk), .dataBlkExt(dataBlkExt), .instFault(instFault),
    .acc1(acc1), .logicResultBit(logicResultBit), .stopped(stopped));
  pie_prog_model i_pie_prog_model (.clk(clk), .instValid(instValid),
    .instOp(instOp), .instKind(instKind), .instParam(instParam),
    .instData(instData), .locWrEn(locWrEn), .locIsCnt(locIsCnt),
    .locIdx(locIdx), .locData(locData));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input pie_pkg::pie_op_t op, input logic [7:0] p,
                     input pie_pkg::pie_blk_t k = pie_pkg::BLK_ORG);
    i_pie_prog_model.issue(op, k, p, {$urandom} | 32'h1);
  endtask : run
  task automatic ld(input pie_pkg::pie_op_t op, input logic [7:0] p,
                    input logic [31:0] d, input logic [31:0] x);
    i_pie_prog_model.issue(op, pie_pkg::BLK_ORG, p, d);
    m[2] = m[1];
    m[1] = x;
    chk(acc1, x);
  endtask : ld
  task automatic arith(input pie_pkg::pie_op_t op, input logic [31:0] x);
    run(op, 8'h00);
    m[1:3] = '{x, m[3], m[4]};
    chk(acc1, x);
  endtask : arith
  // a fresh chain start makes the first scan load the bit
  task automatic setLrb(input logic v, output logic e);
    int k;
    k = 0;
    while (pinIn[k] !== v && k < 127) k++;
    run(pie_pkg::OP_ASSIGN, 8'h7f);
    run(pie_pkg::OP_AND_SCAN, 8'(k));
    e = pinIn[k];
  endtask : setLrb
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200us;
    err_total++;
    test_done();
  end
  initial begin
    logic e;
    logic [9:0] v;
    logic [3:0] t;
    int o;
    rstn = 1'b0;
    pinIn = '0;
    m = '{default: '0};
    lk = pie_pkg::BLK_ORG;
    ln = 8'h00;
    void'($urandom(20));
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    for (int c = 0; c < 2; c++) begin
      v = 10'($urandom_range(0, 999));
      t = 4'($urandom);
      i_pie_prog_model.locWrite(c[0], 7'(c + 10), {t, 2'b00, v});
      ld(c ? pie_pkg::OP_CODED_CNT : pie_pkg::OP_CODED_TMR, 8'(c + 10),
         0, {18'h0, c ? 2'b00 : t[1:0], 4'(v / 100), 4'(v / 10 % 10),
         4'(v % 10)});
      ld(c ? pie_pkg::OP_LOAD_CNT : pie_pkg::OP_LOAD_TMR, 8'(c + 10), 0,
         {22'h0, v});
    end
    for (int i = 0; i < 8; i++) begin
      a = 16'($urandom);
      b = 16'($urandom) | 16'h1;
      ld(pie_pkg::OP_LOAD_CONST, 0, {16'h0, a}, {16'h0, a});
      ld(pie_pkg::OP_LOAD_CONST, 0, {16'h0, b}, {16'h0, b});
      case (i % 4)
        0: arith(pie_pkg::OP_FIX_ADD, {16'h0, a + b});
        1: arith(pie_pkg::OP_FIX_SUB, {16'h0, a - b});
        2: arith(pie_pkg::OP_FIX_MUL, $signed(a) * $signed(b));
        default: arith(pie_pkg::OP_FIX_DIV,
                       {16'h0, 16'($signed(a) / $signed(b))});
      endcase
      arith(pie_pkg::OP_FIX_ADD,
            {m[2][31:16], m[2][15:0] + m[1][15:0]});
    end
    for (int i = 0; i < 4; i++) begin
      ld(pie_pkg::OP_LOAD_CONST, 0, 32'h3fc00000, 32'h3fc00000);
      ld(pie_pkg::OP_LOAD_CONST, 0, 32'h40000000, 32'h40000000);
      arith(pie_pkg::pie_op_t'(pie_pkg::OP_FLT_ADD + i), fr[i]);
    end
    for (int i = 0; i < 8; i++) begin
      pinIn = {$urandom, $urandom, $urandom, $urandom};
      repeat (5) @(negedge clk);
      run(pie_pkg::OP_ASSIGN, 8'h7e);
      for (int j = 0; j < 3; j++) begin
        o = $urandom_range(0, 127);
        run(i[0] ? pie_pkg::OP_OR_SCAN : pie_pkg::OP_AND_SCAN, 8'(o));
        e = j == 0 ? pinIn[o] : i[0] ? e | pinIn[o] : e & pinIn[o];
      end
      o = $urandom_range(0, 125);
      run(pie_pkg::OP_ASSIGN, 8'(o));
      chk(32'(outBits[o]), 32'(e));
      chk(32'(logicResultBit), 32'(e));
    end
    for (int i = 0; i < 10; i++) begin
      setLrb(1'($urandom), e);
      n = i == 9 ? 8'hff : 8'($urandom_range(1, 255));
      kd = pie_pkg::pie_blk_t'(i % 5);
      run(i < 5 ? pie_pkg::OP_CALL_U : pie_pkg::OP_CALL_C, n, kd);
      if (i < 5 || e) begin
        lk = kd;
        ln = n;
      end
      chk(32'(callValid), 32'(i < 5 || e));
      chk({21'h0, callKind, callNum}, {21'h0, lk, ln});
    end
    run(pie_pkg::OP_CALL_U, 8'h00, pie_pkg::BLK_ORG);
    chk({30'h0, callValid, instFault}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      n = 8'((i[1] ? 0 : 2) + i[0]);
      run(i[1] ? pie_pkg::OP_SEL_DX : pie_pkg::OP_SEL_DB, n);
      chk(32'(instFault), 32'(!i[0]));
      if (i[0]) chk({23'h0, dataBlkExt, dataBlk}, {23'h0, i[1], n});
    end
    for (int i = 0; i < 6; i++) begin
      setLrb(i[0], e);
      run(pie_pkg::pie_op_t'(pie_pkg::OP_FINISH + i / 2), 8'h00);
      chk(32'(finishValid), 32'(i / 2 != 1 || e));
    end
    for (int i = 0; i < 4; i++) begin
      run(i == 2 ? pie_pkg::OP_DISPLAY : pie_pkg::OP_IDLE,
          i == 2 ? 8'($urandom) : 8'(i));
      chk({callValid, finishValid, instFault}, 32'(i == 3));
      chk(acc1, m[1]);
    end
    run(pie_pkg::OP_HALT, 8'h00);
    chk({30'h0, instReady, stopped}, 32'h1);
    run(pie_pkg::OP_LOAD_CONST, 8'h00);
    chk(acc1, m[1]);
    test_done();
  end
endmodule : tb_pie_exec
